// File: rtl/csemu_regs.vh
// Register offsets, field positions, reset values and codes for the control store emulation block.
`ifndef CSEMU_REGS_VH
`define CSEMU_REGS_VH
// Byte offsets of the configuration and read-only status registers.
`define CSE_OFF_MCR      8'h00
`define CSE_OFF_RAMBASE  8'h04
`define CSE_OFF_CHSEL    8'h08
`define CSE_OFF_CFG      8'h0C
`define CSE_OFF_STATUS   8'h10
`define CSE_OFF_FETCH    8'h14
`define CSE_OFF_DECODE   8'h18
`define CSE_OFF_IRQ      8'h1C
// Control register fields.
`define CSE_MCR_EMU_BIT  0
`define CSE_MCR_HALF_BIT 1
`define CSE_MCR_RST      32'h0000_0000
`define CSE_RAMBASE_RST  32'h0000_0000
// Channel configuration word fields.
`define CSE_FS_LSB       0
`define CSE_PRI_LSB      4
`define CSE_IE_BIT       6
`define CSE_HSQ_LSB      8
`define CSE_HSR_LSB      10
`define CSE_PSC_LSB      16
`define CSE_PAC_LSB      18
`define CSE_TBS_LSB      21
`define CSE_OUT_BIT      25
`define CSE_CFG_RST      32'h01E0_0000
// Control store geometry in long words, and the RAM byte address width.
`define CSE_CS_WORDS     512
`define CSE_CS_AW        9
`define CSE_RAM_BYTES_AW 11
// Function numbers of the preprogrammed functions.
`define CSE_FN_TACC      4'hF
`define CSE_FN_QOM       4'hE
`define CSE_FN_SER       4'hB
`define CSE_FN_TCAP      4'hA
`endif

// File: rtl/csemu_core.v
// Control store source selection and channel configuration decoding with an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "csemu_regs.vh"

// Operation
// RULE1: With emulation selected, microcode fetches come from emulation RAM, dedicated to coprocessor.
// RULE2: Full-size RAM covers whole control store; half-size RAM covers only half.
// RULE3: Larger RAM serves partly as control store but vanishes wholly from host map.
// RULE4: Emulated control store address range never exceeds the normal control store range.
// RULE5: Host keeps emulation microcode at or below 512 long words.
// RULE6: Host programs RAM base, loads microcode, then sets the emulation select bit.
// RULE7: During emulation the RAM host address window is freed for other peripherals.
// RULE8: Loaded functions execute exactly as ROM functions would.
// RULE9: During emulation no function is fetched from internal microcode ROM.
// RULE10: Priority 00 disables, 01 low, 10 medium, 11 high.
// RULE11: Pin state control 00 per latches, 01 high, 10 low, 11 no force.
// RULE12: Input pin action: none, rising, falling, either; 1xx keeps old field.
// RULE13: Output pin action: no change, high, low, toggle; 1xx keeps old field.
// RULE14: Timebase select picks capture and match counters; all ones keeps selection.
// RULE15: Each channel runs the function numbered in its function select field.
// RULE16: Channel interrupt raised toward host only when its enable bit is one.
// RULE17: Serial function: service 2 receive, 3 transmit; sequence parity none, even, odd.
// RULE18: Queued match: service 1,2,3 init pin same, low, high; sequence modes.
// RULE19: Time accumulation: service 3 initializes; sequence selects four accumulation kinds.
// RULE20: Transition capture: service 1 counter mode, 2 parameter mode; sequence picks options.
// RULE21: Clearing priority stops scheduling but lets the service in progress finish.
// RULE22: RAM microcode follows the same operation, timing and conditions as ROM.
// RULE23: With emulation clear, fetch from ROM and keep the RAM host-mapped.
module csemu_core (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Microengine fetch port
    input  wire        ue_fetch_req,
    input  wire [8:0]  ue_fetch_addr,
    output reg  [31:0] ue_fetch_data,
    output reg         ue_fetch_valid,
    output reg         ue_fetch_fault,
    // Control store ROM port
    output reg         rom_rd,
    output reg  [8:0]  rom_addr,
    input  wire [31:0] rom_data,
    // Emulation RAM port toward the coprocessor
    output reg         emu_rd,
    output reg  [8:0]  emu_addr,
    input  wire [31:0] emu_data,
    // Host map control of the emulation RAM
    input  wire [31:0] host_addr,
    output wire        emulation_ram_host_sel,
    output wire        emulation_ram_map_en,
    // Channel service status from the microengine
    input  wire [15:0] chan_busy,
    input  wire [15:0] chan_event,
    // Interrupt requests toward the host
    output reg  [15:0] chan_irq
);

    // Write response tracking, one-hot.
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RESP = 2'b10;

    // Software-visible registers and the per-channel configuration words.
    reg  [31:0] mcr_r;
    reg  [31:0] rambase_r;
    reg  [3:0]  chsel_r;
    reg  [31:0] cfg_r [0:15];
    // Working copies of timebase and pin action, kept when a reserved code arrives.
    reg  [1:0]  tbs_cur_r [0:15];
    reg  [2:0]  pac_cur_r [0:15];
    reg  [15:0] sched_en_r;
    // Write channel state; an address or data beat that arrives alone waits here.
    reg  [1:0]  wst_r;
    reg         aw_got_r;
    reg         w_got_r;
    reg  [7:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg  [31:0] decode_word;
    reg  [31:0] rd_word;
    reg         rd_ok;
    integer     i;
    integer     j;
    // Fetch fault held one cycle so that it meets the same answer slot as a read.
    reg         fault_pend_r;

    // Control register bits and the fields of the channel chosen by the channel select register.
    wire        emu_on   = mcr_r[`CSE_MCR_EMU_BIT];
    wire        half_ram = mcr_r[`CSE_MCR_HALF_BIT];
    wire [31:0] sel_cfg  = cfg_r[chsel_r];
    wire [1:0]  pri      = sel_cfg[`CSE_PRI_LSB +: 2];
    wire [3:0]  fsel     = sel_cfg[`CSE_FS_LSB +: 4];
    wire [1:0]  hsq      = sel_cfg[`CSE_HSQ_LSB +: 2];
    wire [1:0]  host_service_code      = sel_cfg[`CSE_HSR_LSB +: 2];
    wire [1:0]  pin_state_control_field      = sel_cfg[`CSE_PSC_LSB +: 2];

    // Whole RAM leaves the host map while emulating, whatever part serves as store.
    assign emulation_ram_map_en   = ~emu_on; // RULE3 RULE7 RULE23
    assign emulation_ram_host_sel = ~emu_on &&
        (host_addr[31:`CSE_RAM_BYTES_AW] == rambase_r[31:`CSE_RAM_BYTES_AW]); // RULE23

    // Fetch steering; both sources answer two cycles after the request.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rom_rd         <= 1'b0;
            rom_addr       <= 9'h000;
            emu_rd         <= 1'b0;
            emu_addr       <= 9'h000;
            ue_fetch_valid <= 1'b0;
            ue_fetch_fault <= 1'b0;
            ue_fetch_data  <= 32'h0000_0000;
        end else begin
            // Address is the store width, so the emulated range cannot exceed it.
            rom_rd   <= ue_fetch_req && !emu_on; // RULE9 RULE23
            // Only the lower half is read on a half-size RAM.
            emu_rd   <= ue_fetch_req && emu_on &&
                        !(half_ram && ue_fetch_addr[`CSE_CS_AW-1]); // RULE1 RULE2
            rom_addr <= ue_fetch_addr; // RULE4
            emu_addr <= ue_fetch_addr; // RULE4
            ue_fetch_valid <= rom_rd || emu_rd || fault_pend_r; // RULE22
            ue_fetch_fault <= fault_pend_r;
            // Data is zero when no memory was read, which is the fault answer.
            ue_fetch_data  <= emu_rd ? emu_data : (rom_rd ? rom_data : 32'h0000_0000); // RULE8
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_pend_r <= 1'b0;
        end else begin
            // Upper half is unreachable on a half-size RAM.
            fault_pend_r <= ue_fetch_req && emu_on && half_ram &&
                            ue_fetch_addr[`CSE_CS_AW-1]; // RULE2
        end
    end

    // Scheduling enable per channel; a busy channel finishes its service first.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sched_en_r <= 16'h0000;
            chan_irq   <= 16'h0000;
        end else begin
            for (j = 0; j < 16; j = j + 1) begin
                if (cfg_r[j][`CSE_PRI_LSB +: 2] != 2'b00) begin
                    sched_en_r[j] <= 1'b1; // RULE10
                end else if (!chan_busy[j]) begin
                    sched_en_r[j] <= 1'b0; // RULE21
                end
                // No enable, no request: the event alone never reaches the host.
                chan_irq[j] <= chan_event[j] && cfg_r[j][`CSE_IE_BIT]; // RULE16
            end
        end
    end

    // Decode of the selected channel for software inspection.
    always @* begin
        decode_word = 32'h0000_0000;
        decode_word[3:0] = fsel; // RULE15
        case (pri)
            2'b01:   decode_word[6:4] = 3'b001; // RULE10
            2'b10:   decode_word[6:4] = 3'b010;
            2'b11:   decode_word[6:4] = 3'b100;
            default: decode_word[6:4] = 3'b000;
        endcase
        decode_word[7] = sched_en_r[chsel_r]; // RULE21
        // Pin force is {force, level}; latch mode takes its level from the pin action.
        case (pin_state_control_field)
            2'b00:   decode_word[9:8] = pac_cur_r[chsel_r][0] ? 2'b11 : 2'b10; // RULE11
            2'b01:   decode_word[9:8] = 2'b11;
            2'b10:   decode_word[9:8] = 2'b10;
            default: decode_word[9:8] = 2'b00;
        endcase
        decode_word[12:10] = pac_cur_r[chsel_r]; // RULE12 RULE13
        decode_word[13]    = sel_cfg[`CSE_OUT_BIT];
        decode_word[15:14] = tbs_cur_r[chsel_r]; // RULE14
        case (fsel)
            // Serial: [16] receive, [17] transmit, [19:18] parity none, even, odd.
            `CSE_FN_SER: begin
                decode_word[16] = (host_service_code == 2'd2); // RULE17
                decode_word[17] = (host_service_code == 2'd3);
                decode_word[19:18] = hsq[1] ? (hsq[0] ? 2'd2 : 2'd1) : 2'd0;
            end
            // Queued match: [16] initialise, [18:17] pin start, [21:20] single, loop, continuous.
            `CSE_FN_QOM: begin
                decode_word[16] = (host_service_code != 2'd0); // RULE18
                decode_word[18:17] = host_service_code;
                decode_word[21:20] = hsq[1] ? 2'd2 : {1'b0, hsq[0]};
            end
            // Time accumulation: [16] initialise, [19:18] accumulation kind.
            `CSE_FN_TACC: begin
                decode_word[16] = (host_service_code == 2'd3); // RULE19
                decode_word[19:18] = hsq;
            end
            // Transition capture: [16] counter mode, [17] parameter mode, [18] continual, [19] links.
            `CSE_FN_TCAP: begin
                decode_word[16] = (host_service_code == 2'd1); // RULE20
                decode_word[17] = (host_service_code == 2'd2);
                decode_word[18] = hsq[0];
                decode_word[19] = hsq[1];
            end
            // Other functions carry no host code decode.
            default: begin
                decode_word[23:22] = 2'b00;
            end
        endcase
    end

    // AXI4-Lite write path; address and data accepted in either order.
    assign s_axi_awready = (wst_r == ST_IDLE) && !aw_got_r;
    assign s_axi_wready  = (wst_r == ST_IDLE) && !w_got_r;
    // Ready stays low while a response waits, so only one write is ever open.

    wire       aw_now = s_axi_awvalid && s_axi_awready;
    wire       w_now  = s_axi_wvalid && s_axi_wready;
    wire [7:0] wa     = aw_got_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wd    = w_got_r ? w_data_r : s_axi_wdata;
    wire [3:0] ws     = w_got_r ? w_strb_r : s_axi_wstrb;
    wire       do_wr  = (wst_r == ST_IDLE) && (aw_got_r || aw_now) && (w_got_r || w_now);

    // Byte-strobe merge of a write into the old register value.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (st[k]) begin
                    merge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction

    reg [31:0] new_cfg;
    always @* begin
        new_cfg = merge(sel_cfg, wd, ws);
        // Reserved codes keep the current field.
        if (new_cfg[`CSE_PAC_LSB + 2]) begin
            new_cfg[`CSE_PAC_LSB +: 3] = sel_cfg[`CSE_PAC_LSB +: 3]; // RULE12 RULE13
        end
        // All ones is stored as written; the working copy keeps the old choice.
        if (new_cfg[`CSE_TBS_LSB +: 4] == 4'hF) begin
            new_cfg[`CSE_TBS_LSB +: 4] = 4'hF; // RULE14
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            wst_r        <= ST_IDLE;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            mcr_r        <= `CSE_MCR_RST;
            rambase_r    <= `CSE_RAMBASE_RST;
            chsel_r      <= 4'h0;
            for (i = 0; i < 16; i = i + 1) begin
                cfg_r[i]     <= `CSE_CFG_RST;
                tbs_cur_r[i] <= 2'b00;
                pac_cur_r[i] <= 3'b000;
            end
        end else begin
            for (i = 0; i < 16; i = i + 1) begin
                // Capture/match choice follows the field unless it is all ones.
                if (cfg_r[i][`CSE_TBS_LSB +: 4] != 4'hF) begin
                    tbs_cur_r[i] <= {cfg_r[i][`CSE_TBS_LSB + 1], cfg_r[i][`CSE_TBS_LSB]}; // RULE14
                end
                pac_cur_r[i] <= cfg_r[i][`CSE_PAC_LSB +: 3];
            end
            // A beat that arrives without its partner is held until the partner comes.
            if (aw_now && !do_wr) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_now && !do_wr) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                wst_r        <= ST_RESP;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (wa)
                    // Only the select and half-size bits are implemented.
                    `CSE_OFF_MCR:     mcr_r     <= merge(mcr_r, wd, ws) & 32'h0000_0003;
                    // Base may move only while the RAM is host-mapped.
                    `CSE_OFF_RAMBASE: if (!emu_on) rambase_r <= merge(rambase_r, wd, ws); // RULE6
                    `CSE_OFF_CHSEL:   if (ws[0]) chsel_r <= wd[3:0];
                    `CSE_OFF_CFG:     cfg_r[chsel_r] <= new_cfg;
                    // Read-only offsets ignore the data but still answer OKAY.
                    `CSE_OFF_STATUS, `CSE_OFF_FETCH, `CSE_OFF_DECODE, `CSE_OFF_IRQ: begin
                        s_axi_bresp <= 2'b00;
                    end
                    // Unmapped offsets answer with a slave error.
                    default:          s_axi_bresp <= 2'b10;
                endcase
            end
            if (wst_r == ST_RESP && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                wst_r        <= ST_IDLE;
            end
        end
    end

    // AXI4-Lite read path.
    assign s_axi_arready = !s_axi_rvalid;

    // Unmapped offsets read as zero with a slave error.
    always @* begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `CSE_OFF_MCR:     rd_word = mcr_r;
            `CSE_OFF_RAMBASE: rd_word = rambase_r;
            `CSE_OFF_CHSEL:   rd_word = {28'h000_0000, chsel_r};
            `CSE_OFF_CFG:     rd_word = sel_cfg;
            `CSE_OFF_STATUS:  rd_word = {16'h0000, sched_en_r};
            `CSE_OFF_FETCH:   rd_word = {29'h0000_0000, emulation_ram_map_en, emu_on, half_ram};
            `CSE_OFF_DECODE:  rd_word = decode_word;
            `CSE_OFF_IRQ:     rd_word = {16'h0000, chan_irq};
            default:          rd_ok   = 1'b0;
        endcase
    end

    // Read data is registered and held until the master takes it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // csemu_core

`default_nettype wire

// File: bench/csemu_asserts.sv
// Concurrent checks on the ports of the control store emulation block.
`timescale 1ns/1ps
`default_nettype none
module csemu_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write response
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Fetch path
    input wire logic        ue_fetch_req,
    input wire logic [8:0]  ue_fetch_addr,
    input wire logic [31:0] ue_fetch_data,
    input wire logic        ue_fetch_valid,
    input wire logic        ue_fetch_fault,
    input wire logic        rom_rd,
    input wire logic [8:0]  rom_addr,
    input wire logic [31:0] rom_data,
    input wire logic        emu_rd,
    input wire logic [8:0]  emu_addr,
    input wire logic [31:0] emu_data,
    // Host map and interrupts
    input wire logic        emulation_ram_host_sel,
    input wire logic        emulation_ram_map_en,
    input wire logic [15:0] chan_event,
    input wire logic [15:0] chan_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rom_fetch: assert property (ue_fetch_req && emulation_ram_map_en |=>
        rom_rd && !emu_rd && rom_addr == $past(ue_fetch_addr)) else $error("ROM fetch missing");
    a_emu_fetch: assert property (ue_fetch_req && !emulation_ram_map_en && !ue_fetch_addr[8] |=>
        emu_rd && !rom_rd && emu_addr == $past(ue_fetch_addr)) else $error("RAM fetch missing");
    a_rom_idle: assert property (!emulation_ram_map_en && !$past(emulation_ram_map_en) |->
        !rom_rd) else $error("ROM read during emulation");
    a_rom_data: assert property (rom_rd |=> ue_fetch_valid && !ue_fetch_fault &&
        ue_fetch_data == $past(rom_data)) else $error("ROM word not returned");
    a_emu_data: assert property (emu_rd |=> ue_fetch_valid && !ue_fetch_fault &&
        ue_fetch_data == $past(emu_data)) else $error("RAM word not returned");
    a_half_fault: assert property (ue_fetch_fault |-> ue_fetch_valid &&
        ue_fetch_data == 32'h0000_0000 && $past(ue_fetch_addr[8], 2)) else $error("Bad fault");
    a_fetch_lat: assert property (ue_fetch_req |-> ##2 ue_fetch_valid)
        else $error("Fetch answer late");
    a_ram_unmap: assert property (!emulation_ram_map_en |-> !emulation_ram_host_sel)
        else $error("RAM still mapped");
    a_irq_cause: assert property ((chan_irq & ~$past(chan_event)) == 16'h0000)
        else $error("Interrupt without event");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped");
    c_emu: cover property (emu_rd);
    c_fault: cover property (ue_fetch_fault);
    c_irq: cover property (chan_irq != 16'h0000);
endmodule // csemu_asserts
bind csemu_core csemu_asserts u_asserts (.*);
`default_nettype wire

// File: bench/csemu_mem.sv
// Far-side model of the control store ROM and emulation RAM read ports.
`timescale 1ns/1ps
`default_nettype none
module csemu_mem (
    // Clock
    input  wire logic        aclk,
    // ROM port
    input  wire logic        rom_rd,
    input  wire logic [8:0]  rom_addr,
    output var logic  [31:0] rom_data,
    // Emulation RAM port
    input  wire logic        emu_rd,
    input  wire logic [8:0]  emu_addr,
    output var logic  [31:0] emu_data
);
    // Unread ports show a pattern that flips every cycle, never stale words.
    logic [31:0] junk_r = 32'h0F3C_96A5;
    always @(posedge aclk) junk_r <= ~junk_r;
    assign rom_data = rom_rd ? {16'hC5C5, 7'h00, rom_addr} : junk_r;
    assign emu_data = emu_rd ? {16'h3A3A, 7'h00, emu_addr} : junk_r;
endmodule // csemu_mem
`default_nettype wire

// File: bench/csemu_core_test.sv
// Self-checking testbench of the control store emulation block.
`timescale 1ns/1ps
`default_nettype none
module csemu_core_test;
    logic        aclk = 0, aresetn = 0, ue_fetch_req = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, host_addr = 32'h0, v, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [8:0]  ue_fetch_addr = 9'h000;
    logic [15:0] chan_busy = 16'h0, chan_event = 16'h0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         ue_fetch_valid, ue_fetch_fault, rom_rd, emu_rd;
    wire         emulation_ram_host_sel, emulation_ram_map_en;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata, ue_fetch_data, rom_data, emu_data;
    wire [8:0]   rom_addr, emu_addr;
    wire [15:0]  chan_irq;
    int          bad_count = 0, n_tests = 0, seed = 32'h3614, i;
    csemu_core u_dut (.*);
    csemu_mem u_mem (.*);
    initial forever #5 aclk = ~aclk;
    task end_of_test;
        if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    task tmo;
        bad_count++;
        end_of_test;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (k == 40) tmo;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task rdr(input logic [7:0] a, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        if (k == 40) tmo;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task cfg(input logic [31:0] w);
        wr(8'h0C, w, 2'b00);
        rdr(8'h18, 2'b00);
    endtask
    task pulse;
        @(posedge aclk) chan_event <= 16'h0001;
        @(posedge aclk) chan_event <= 16'h0000;
        @(posedge aclk);
    endtask
    function logic [31:0] word(input logic emulation_select_bit, input logic [8:0] a);
        return {emulation_select_bit ? 16'h3A3A : 16'hC5C5, 7'h00, a};
    endfunction
    // Expected host code decode of the four preprogrammed functions.
    function logic [7:0] fexp(input logic [3:0] f, input logic [1:0] s, input logic [1:0] q);
        case (f)
            4'hB: return {4'h0, ((q < 2'd2) ? 2'd0 : q - 2'd1), (s == 2'd3), (s == 2'd2)};
            4'hE: return {2'h0, ((q == 2'd3) ? 2'd2 : q), 1'b0, s, (s != 2'd0)};
            4'hF: return {4'h0, q, 1'b0, (s == 2'd3)};
            default: return {4'h0, q[1], q[0], (s == 2'd2), (s == 2'd1)};
        endcase
    endfunction
    task fetch(input logic [8:0] a, input logic [31:0] e, input logic f);
        int k;
        @(posedge aclk);
        ue_fetch_req <= 1'b1;
        ue_fetch_addr <= a;
        @(posedge aclk) ue_fetch_req <= 1'b0;
        for (k = 0; k < 6; k++) begin
            @(posedge aclk);
            if (ue_fetch_valid === 1'b1) break;
        end
        if (k == 6) tmo;
        chk("fetch_data", e, ue_fetch_data);
        chk("fetch_fault", {31'h0, f}, {31'h0, ue_fetch_fault});
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(8'h00, 2'b00);
        chk("mcr", 32'h0, rd);
        rdr(8'h0C, 2'b00);
        chk("cfg", 32'h01E0_0000, rd);
        rdr(8'h40, 2'b10);
        wr(8'h40, 32'h1, 2'b10);
        wr(8'h04, 32'h0001_0000, 2'b00);
        @(posedge aclk) host_addr <= 32'h0001_0000 | ($random(seed) & 32'h7FF);
        @(posedge aclk);
        chk("map_en", 32'h1, emulation_ram_map_en);
        chk("host_sel", 32'h1, emulation_ram_host_sel);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            fetch(v[8:0], word(1'b0, v[8:0]), 1'b0);
        end
        wr(8'h00, 32'h1, 2'b00);
        @(posedge aclk);
        chk("map_en", 32'h0, emulation_ram_map_en);
        chk("host_sel", 32'h0, emulation_ram_host_sel);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            fetch(v[8:0], word(1'b1, v[8:0]), 1'b0);
        end
        wr(8'h00, 32'h3, 2'b00);
        fetch(9'h100, 32'h0, 1'b1);
        fetch(9'h0FF, word(1'b1, 9'h0FF), 1'b0);
        wr(8'h00, 32'h0, 2'b00);
        fetch(9'h1FF, word(1'b0, 9'h1FF), 1'b0);
        wr(8'h08, 32'h0, 2'b00);
        for (i = 0; i < 4; i++) begin
            v = $random(seed) & 32'hF;
            cfg(v | (i << 4));
            chk("fsel", v, rd & 32'hF);
            chk("pri", (i == 0) ? 32'h0 : (32'h80 | (32'h8 << i)), rd & 32'hF0);
        end
        for (i = 1; i < 4; i++) begin
            cfg(i << 16);
            chk("psc", (i == 1) ? 32'h300 : 32'h200 * (i == 2), rd & ((i == 3) ? 32'h200 : 32'h300));
        end
        cfg(32'h3 << 18);
        cfg((32'h4 | ($random(seed) & 32'h3)) << 18);
        chk("pac_in", 32'h0C00, rd & 32'h3C00);
        cfg(32'h0200_0000 | 32'h1 << 18);
        cfg(32'h0200_0000 | 32'h5 << 18);
        chk("pac_out", 32'h2400, rd & 32'h3C00);
        cfg(32'h2 << 21);
        chk("tbs", 32'h8000, rd & 32'hC000);
        cfg(32'hF << 21);
        chk("tbs_keep", 32'h8000, rd & 32'hC000);
        for (i = 0; i < 16; i++) begin
            v = $random(seed) & 32'h0F00;
            v[3:0] = 16'hBEFA >> (4 * (i % 4));
            cfg(v);
            rd = rd >> 16;
            chk("fn", {24'h0, fexp(v[3:0], v[11:10], v[9:8])}, rd);
        end
        cfg(32'h70);
        pulse;
        chk("irq_on", 32'h1, chan_irq);
        cfg(32'h30);
        pulse;
        chk("irq_off", 32'h0, chan_irq);
        @(posedge aclk) chan_busy <= 16'h0001;
        cfg(32'h0);
        rdr(8'h10, 2'b00);
        chk("sched_busy", 32'h1, rd & 32'h1);
        @(posedge aclk) chan_busy <= 16'h0000;
        repeat (3) @(posedge aclk);
        rdr(8'h10, 2'b00);
        chk("sched_idle", 32'h0, rd & 32'h1);
        end_of_test;
    end
endmodule // csemu_core_test
`default_nettype wire
